// ### pkg/rxgca_pkg.sv
package rxgca_pkg;
   // register byte addresses on the AXI4-Lite window
   localparam logic [7:0] RXGCA_GLOBAL_OFS = 8'h40;
   localparam logic [7:0] RXGCA_ALIAS_OFS  = 8'h60;
   localparam int         RXGCA_ADDR_W     = 8;
   localparam int         RXGCA_DATA_W     = 32;

   // field positions of the shared control word
   localparam int RXGCA_RX_BIT_DIV_POS   = 0;
   localparam int RXGCA_RX_FAST_DIV_POS  = 1;
   localparam int RXGCA_RX_SER_POS       = 2;
   localparam int RXGCA_RX_SM_POS        = 3;
   localparam int RXGCA_RX_FSG_POS       = 4;
   localparam int RXGCA_TX_BIT_DIV_POS   = 8;
   localparam int RXGCA_TX_FAST_DIV_POS  = 9;
   localparam int RXGCA_TX_SER_POS       = 10;
   localparam int RXGCA_TX_SM_POS        = 11;
   localparam int RXGCA_TX_FSG_POS       = 12;

   // which bits each register may change; everything else reads zero
   localparam logic [31:0] RXGCA_RX_MASK   = 32'h0000001F;
   localparam logic [31:0] RXGCA_TX_MASK   = 32'h00001F00;
   localparam logic [31:0] RXGCA_CTL_RESET = 32'h00000000;

   // AXI response codes
   localparam logic [1:0] RXGCA_RESP_OKAY   = 2'h0;
   localparam logic [1:0] RXGCA_RESP_SLVERR = 2'h2;

   // register select produced by the address decoder
   typedef enum logic [1:0]
   {
      RXGCA_SEL_NONE   = 2'b00,
      RXGCA_SEL_GLOBAL = 2'b01,
      RXGCA_SEL_ALIAS  = 2'b10
   } rxgca_sel_t;
endpackage

// ### pkg/rxgca_ctl_if.sv
`timescale 1ns/1ps
interface rxgca_ctl_if;
   import rxgca_pkg::*;
   logic       commit;   // one-cycle write strobe
   rxgca_sel_t target;   // register being written
   logic [31:0] wdata;   // write data
   logic [3:0]  wstrb;   // byte enables
   logic [31:0] value;   // current shared control word

   modport store
   (
      input  commit,
      input  target,
      input  wdata,
      input  wstrb,
      output value
   );
   modport bus
   (
      output commit,
      output target,
      output wdata,
      output wstrb,
      input  value
   );
endinterface

// ### logic/rxgca_rst_sync.sv
`timescale 1ns/1ps
module rxgca_rst_sync
(
   input  wire logic clk,
   input  wire logic rst_in_n,
   output logic      rst_out_n
);
   logic stage1;   // first stage, read only by the second

   // assert at once, release after two clean edges to avoid metastable release
   always_ff @(posedge clk or negedge rst_in_n)
   begin
      if (!rst_in_n)
      begin
         stage1    <= 1'b0;
         rst_out_n <= 1'b0;
      end
      else
      begin
         stage1    <= 1'b1;
         rst_out_n <= stage1;
      end
   end
endmodule

// ### logic/rxgca_ctl_store.sv
`timescale 1ns/1ps
module rxgca_ctl_store
(
   input  wire logic     clk,
   input  wire logic     rst_n,
   rxgca_ctl_if.store    ctl
);
   import rxgca_pkg::*;

   logic [31:0] ctl_word;   // the one physical copy behind both addresses
   logic [31:0] byte_mask;  // byte enables widened to bits
   logic [31:0] wr_mask;    // bits this write may change

   // widen the byte strobes
   always_comb
   begin
      byte_mask = {{8{ctl.wstrb[3]}}, {8{ctl.wstrb[2]}},
                   {8{ctl.wstrb[1]}}, {8{ctl.wstrb[0]}}};
   end

   // the alias reaches only the receive field, the main address both fields
   always_comb
   begin
      case (ctl.target)
         RXGCA_SEL_GLOBAL: wr_mask = byte_mask & (RXGCA_RX_MASK | RXGCA_TX_MASK);
         RXGCA_SEL_ALIAS:  wr_mask = byte_mask & RXGCA_RX_MASK;
         default:          wr_mask = 32'h00000000;
      endcase
   end

   // one register shared by both views; reserved bits never load
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl_word <= RXGCA_CTL_RESET;
      end
      else if (ctl.commit)
      begin
         ctl_word <= (ctl_word & ~wr_mask) | (ctl.wdata & wr_mask);
      end
   end

   assign ctl.value = ctl_word;
endmodule

// ### logic/rxgca_top.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rxgca_top
(
   input  wire logic                            CORE_CLK,
   input  wire logic                            RST_N,
   // write address channel
   input  wire logic [rxgca_pkg::RXGCA_ADDR_W-1:0] AWADDR,
   input  wire logic [2:0]                      AWPROT,
   input  wire logic                            AWVALID,
   output logic                                 AWREADY,
   // write data channel
   input  wire logic [rxgca_pkg::RXGCA_DATA_W-1:0] WDATA,
   input  wire logic [3:0]                      WSTRB,
   input  wire logic                            WVALID,
   output logic                                 WREADY,
   // write response channel
   output logic [1:0]                           BRESP,
   output logic                                 BVALID,
   input  wire logic                            BREADY,
   // read address channel
   input  wire logic [rxgca_pkg::RXGCA_ADDR_W-1:0] ARADDR,
   input  wire logic [2:0]                      ARPROT,
   input  wire logic                            ARVALID,
   output logic                                 ARREADY,
   // read data channel
   output logic [rxgca_pkg::RXGCA_DATA_W-1:0]   RDATA,
   output logic [1:0]                           RRESP,
   output logic                                 RVALID,
   input  wire logic                            RREADY,
   // receive section releases, high lets the unit run
   output logic                                 RX_FRAME_SYNC_GEN_RELEASE,
   output logic                                 RX_STATE_MACHINE_RELEASE,
   output logic                                 RX_SERIALIZER_RELEASE,
   output logic                                 RX_FAST_DIVIDER_RELEASE,
   output logic                                 RX_BIT_DIVIDER_RELEASE,
   // transmit section releases, written only through the main address
   output logic                                 TX_FRAME_SYNC_GEN_RELEASE,
   output logic                                 TX_STATE_MACHINE_RELEASE,
   output logic                                 TX_SERIALIZER_RELEASE,
   output logic                                 TX_FAST_DIVIDER_RELEASE,
   output logic                                 TX_BIT_DIVIDER_RELEASE
);
   import rxgca_pkg::*;

   // bus timing in brief:
   // - address and data are taken on their own handshakes, in either order
   // - the store loads one edge after the later half, and the answer rises
   //   on that same edge, so software never sees a half-applied write
   // - each ready stays low from its handshake until one edge after the
   //   answer is taken; that allows one write and one read in flight and
   //   spares the slave any queue, at the price of some bus throughput
   // - a read and a write landing on one edge see the old word, because
   //   the write is still one edge away from the store
   // - the release outputs are the stored bits, so they move on the very
   //   edge that loads the store and need no separate register

   logic                    rst_n;      // synchronised reset
   rxgca_ctl_if             ctl ();     // path to the shared store

   // write side state
   logic                    aw_held;    // address captured, waiting
   logic                    w_held;     // data captured, waiting
   logic [RXGCA_ADDR_W-1:0] aw_addr;    // captured write address
   logic [RXGCA_DATA_W-1:0] w_data;     // captured write data
   logic [3:0]              w_strb;     // captured byte enables
   rxgca_sel_t              wr_sel;     // decoded write target

   // read side state
   rxgca_sel_t              rd_sel;     // decoded read target

   // protection bits carry no meaning here
   // folded only so the pins are read; they never gate an access
   logic                    prot_unused;
   assign prot_unused = ^{AWPROT, ARPROT};

   // map a byte address onto a register; low two bits must be zero
   function automatic rxgca_sel_t decode(input logic [RXGCA_ADDR_W-1:0] a);
      rxgca_sel_t s;
      // unaligned or unlisted addresses fall through to no register
      s = RXGCA_SEL_NONE;
      if (a == RXGCA_GLOBAL_OFS)
      begin
         s = RXGCA_SEL_GLOBAL;
      end
      else if (a == RXGCA_ALIAS_OFS)
      begin
         s = RXGCA_SEL_ALIAS;
      end
      return s;
   endfunction

   // only the two control fields are ever shown; the mask keeps reserved
   // positions at zero on the bus even if the store grows more bits later
   function automatic logic [RXGCA_DATA_W-1:0] visible_word(input logic [31:0] w);
      logic [RXGCA_DATA_W-1:0] v;
      v = w & (RXGCA_RX_MASK | RXGCA_TX_MASK);
      return v;
   endfunction

   // release the incoming reset through two flops
   // everything below sees only this copy, so no flop leaves reset early
   rxgca_rst_sync u_rst_sync
   (
      .clk       (CORE_CLK),
      .rst_in_n  (RST_N),
      .rst_out_n (rst_n)
   );

   // the one control register behind both addresses
   // either address writes here, so both views agree from the next edge on
   rxgca_ctl_store u_store
   (
      .clk   (CORE_CLK),
      .rst_n (rst_n),
      .ctl   (ctl.store)
   );

   // commit when both halves of a write are in and no answer is pending
   // the pending answer blocks a second commit of the same held write
   assign wr_sel     = decode(aw_addr);
   assign ctl.commit = aw_held && w_held && !BVALID;
   assign ctl.target = wr_sel;
   assign ctl.wdata  = w_data;
   assign ctl.wstrb  = w_strb;

   // write address channel; ready drops while an address is held
   // holding ready low keeps the decoded target still under a pending commit
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // nothing is offered until reset has fully released
         AWREADY <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= '0;
      end
      else if (AWREADY && AWVALID)
      begin
         // address taken; no other until this write is answered
         AWREADY <= 1'b0;
         aw_held <= 1'b1;
         aw_addr <= AWADDR;
      end
      else if (BVALID && BREADY)
      begin
         // answer taken, the held address is spent
         aw_held <= 1'b0;
      end
      else if (!aw_held && !BVALID)
      begin
         // idle again, offer to take the next address
         AWREADY <= 1'b1;
      end
   end

   // write data channel, independent of the address so either may come first
   // strobes travel with the data, so a narrow write only limits which bytes load
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // nothing held after reset
         WREADY <= 1'b0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= 4'h0;
      end
      else if (WREADY && WVALID)
      begin
         // data taken; no other until this write is answered
         WREADY <= 1'b0;
         w_held <= 1'b1;
         w_data <= WDATA;
         w_strb <= WSTRB;
      end
      else if (BVALID && BREADY)
      begin
         // answer taken, the held data is spent
         w_held <= 1'b0;
      end
      else if (!w_held && !BVALID)
      begin
         // idle again, offer to take the next data word
         WREADY <= 1'b1;
      end
   end

   // write response; reserved bits written by software simply drop out
   // the answer waits on the master as long as it likes; nothing times out here
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // no answer pending after reset
         BVALID <= 1'b0;
         BRESP  <= RXGCA_RESP_OKAY;
      end
      else if (ctl.commit)
      begin
         // the store loads on this edge too, so the answer never runs ahead
         BVALID <= 1'b1;
         // unmapped address gets an error, nothing is stored
         BRESP  <= (wr_sel == RXGCA_SEL_NONE) ? RXGCA_RESP_SLVERR : RXGCA_RESP_OKAY;
      end
      else if (BVALID && BREADY)
      begin
         // master took the answer; the readies return one edge later
         BVALID <= 1'b0;
      end
   end

   // read address channel; one read in flight, ready stays low until answered
   // limitation: after an answer the next read address waits two edges
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // nothing taken until reset has fully released
         ARREADY <= 1'b0;
      end
      else if (ARREADY && ARVALID)
      begin
         // request taken; one read at a time, so no queue is needed
         ARREADY <= 1'b0;
      end
      else if (!RVALID)
      begin
         // no answer pending, offer to take the next address
         ARREADY <= 1'b1;
      end
   end

   // decoded straight from the bus, used only on the edge the address is taken
   assign rd_sel = decode(ARADDR);

   // read data: both addresses show the full word, transmit bits included
   always_ff @(posedge CORE_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // the bus shows zeros until the first read
         RVALID <= 1'b0;
         RDATA  <= '0;
         RRESP  <= RXGCA_RESP_OKAY;
      end
      else if (ARREADY && ARVALID)
      begin
         RVALID <= 1'b1;
         case (rd_sel)
            RXGCA_SEL_GLOBAL:
            begin
               // main address, the same full word
               RDATA <= visible_word(ctl.value);
               RRESP <= RXGCA_RESP_OKAY;
            end
            RXGCA_SEL_ALIAS:
            begin
               // reserved positions are zero in the store itself
               RDATA <= visible_word(ctl.value);
               RRESP <= RXGCA_RESP_OKAY;
            end
            default:
            begin
               // unmapped: zeros and an error, nothing else changes
               RDATA <= '0;
               RRESP <= RXGCA_RESP_SLVERR;
            end
         endcase
      end
      else if (RVALID && RREADY)
      begin
         // master took the data
         RVALID <= 1'b0;
      end
   end

   // release levels are the stored bits themselves, so no extra delay;
   // a low bit holds its unit in reset, a high bit lets it run
   // receive group, reachable through either address
   assign RX_FRAME_SYNC_GEN_RELEASE = ctl.value[RXGCA_RX_FSG_POS];
   assign RX_STATE_MACHINE_RELEASE  = ctl.value[RXGCA_RX_SM_POS];
   assign RX_SERIALIZER_RELEASE     = ctl.value[RXGCA_RX_SER_POS];
   assign RX_FAST_DIVIDER_RELEASE   = ctl.value[RXGCA_RX_FAST_DIV_POS];
   assign RX_BIT_DIVIDER_RELEASE    = ctl.value[RXGCA_RX_BIT_DIV_POS];

   // transmit group, only the main address can change these
   assign TX_FRAME_SYNC_GEN_RELEASE = ctl.value[RXGCA_TX_FSG_POS];
   assign TX_STATE_MACHINE_RELEASE  = ctl.value[RXGCA_TX_SM_POS];
   assign TX_SERIALIZER_RELEASE     = ctl.value[RXGCA_TX_SER_POS];
   assign TX_FAST_DIVIDER_RELEASE   = ctl.value[RXGCA_TX_FAST_DIV_POS];
   assign TX_BIT_DIVIDER_RELEASE    = ctl.value[RXGCA_TX_BIT_DIV_POS];
endmodule

// ### tb/rxgca_props.sv
`timescale 1ns/1ps
module rxgca_props
(
   input wire logic        CORE_CLK,
   input wire logic        RST_N,
   input wire logic [7:0]  AWADDR,
   input wire logic        AWVALID,
   input wire logic        AWREADY,
   input wire logic        WVALID,
   input wire logic        WREADY,
   input wire logic [1:0]  BRESP,
   input wire logic        BVALID,
   input wire logic        BREADY,
   input wire logic        ARVALID,
   input wire logic        ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0]  RRESP,
   input wire logic        RVALID,
   input wire logic        RREADY,
   input wire logic        RX_FRAME_SYNC_GEN_RELEASE,
   input wire logic        RX_STATE_MACHINE_RELEASE,
   input wire logic        RX_SERIALIZER_RELEASE,
   input wire logic        RX_FAST_DIVIDER_RELEASE,
   input wire logic        RX_BIT_DIVIDER_RELEASE,
   input wire logic        TX_FRAME_SYNC_GEN_RELEASE,
   input wire logic        TX_STATE_MACHINE_RELEASE,
   input wire logic        TX_SERIALIZER_RELEASE,
   input wire logic        TX_FAST_DIVIDER_RELEASE,
   input wire logic        TX_BIT_DIVIDER_RELEASE
);
   import rxgca_pkg::*;
   // release pins gathered in register bit order
   wire [4:0] rx = {RX_FRAME_SYNC_GEN_RELEASE, RX_STATE_MACHINE_RELEASE,
                    RX_SERIALIZER_RELEASE, RX_FAST_DIVIDER_RELEASE, RX_BIT_DIVIDER_RELEASE};
   wire [4:0] tx = {TX_FRAME_SYNC_GEN_RELEASE, TX_STATE_MACHINE_RELEASE,
                    TX_SERIALIZER_RELEASE, TX_FAST_DIVIDER_RELEASE, TX_BIT_DIVIDER_RELEASE};
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // address and data accepted on one edge
   sequence both_taken;
      AWVALID && AWREADY && WVALID && WREADY;
   endsequence
   sequence rd_taken;
      ARVALID && ARREADY;
   endsequence
   // a write through the alias, both halves taken on one edge
   sequence alias_wr;
      both_taken ##0 AWADDR == RXGCA_ALIAS_OFS;
   endsequence
   // the answer rises on the edge that loads the store, so it is seen two edges on
   wr_answer_a: assert property (both_taken |-> ##2 BVALID)
      else $error("write answer late");
   alias_tx_a: assert property (alias_wr |-> ##2 tx == $past(tx, 2))
      else $error("alias write moved transmit bits");
   rx_change_a: assert property (!$stable(rx) |-> $rose(BVALID))
      else $error("receive bits moved without a write");
   tx_change_a: assert property (!$stable(tx) |-> $rose(BVALID))
      else $error("transmit bits moved without a write");
   rd_whole_a: assert property (rd_taken |=> RVALID && (RRESP != RXGCA_RESP_OKAY ||
      RDATA[12:0] == {$past(tx), 3'h0, $past(rx)}))
      else $error("read data differs from control word");
   rd_reserved_a: assert property (RVALID |-> RDATA[31:13] == 19'h0 && RDATA[7:5] == 3'h0)
      else $error("reserved bits read nonzero");
   b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
   r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
   rst_zero_a: assert property ($rose(RST_N) |-> rx == 5'h00 && tx == 5'h00)
      else $error("control bits not cleared by reset");
endmodule
bind rxgca_top rxgca_props u_props (.*);

// ### tb/test_receiver_global_control_alias.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR %0t got %h expected %h", $time, (g), (e)); end end
module test_receiver_global_control_alias;
   import rxgca_pkg::*;
   logic        CORE_CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [7:0]  AWADDR, ARADDR;
   logic [2:0]  AWPROT, ARPROT;
   logic [31:0] WDATA, RDATA;
   logic [3:0]  WSTRB;
   logic [1:0]  BRESP, RRESP;
   logic        RX_FRAME_SYNC_GEN_RELEASE, RX_STATE_MACHINE_RELEASE, RX_SERIALIZER_RELEASE;
   logic        RX_FAST_DIVIDER_RELEASE, RX_BIT_DIVIDER_RELEASE, TX_FRAME_SYNC_GEN_RELEASE;
   logic        TX_STATE_MACHINE_RELEASE, TX_SERIALIZER_RELEASE, TX_FAST_DIVIDER_RELEASE;
   logic        TX_BIT_DIVIDER_RELEASE;
   int          n_fail = 0;
   int          checked = 0;
   // release pins in register bit order
   wire [4:0] rx = {RX_FRAME_SYNC_GEN_RELEASE, RX_STATE_MACHINE_RELEASE,
                    RX_SERIALIZER_RELEASE, RX_FAST_DIVIDER_RELEASE, RX_BIT_DIVIDER_RELEASE};
   wire [4:0] tx = {TX_FRAME_SYNC_GEN_RELEASE, TX_STATE_MACHINE_RELEASE,
                    TX_SERIALIZER_RELEASE, TX_FAST_DIVIDER_RELEASE, TX_BIT_DIVIDER_RELEASE};
   rxgca_top dut (.*);
   // 40 MHz core clock
   initial
   begin
      CORE_CLK = 1'h0;
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end
   // single exit point for the whole run
   task close_out;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one edge, with a cap so a dead handshake cannot hang the run
   task automatic tick(inout int n);
      @(posedge CORE_CLK);
      n++;
      if (n > 40)
      begin
         n_fail++;
         $display("ERROR %0t bus handshake timed out", $time);
         close_out();
      end
   endtask
   // full write: both channels offered together, held until each is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      int n;
      n = 0;
      AWADDR <= a;
      WDATA <= d;
      WSTRB <= s;
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      BREADY <= 1'h1;
      forever
      begin
         tick(n);
         if (AWREADY) AWVALID <= 1'h0;
         if (WREADY) WVALID <= 1'h0;
         if (BVALID) break;
      end
      `CHK(BRESP, r)
      BREADY <= 1'h0;
      // extra edge so the next call never reassigns in this time step
      @(posedge CORE_CLK);
   endtask
   // full read with expected data and response
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      ARADDR <= a;
      ARVALID <= 1'h1;
      RREADY <= 1'h1;
      forever
      begin
         tick(n);
         if (ARREADY) ARVALID <= 1'h0;
         if (RVALID) break;
      end
      `CHK(RDATA, d)
      `CHK(RRESP, r)
      RREADY <= 1'h0;
      @(posedge CORE_CLK);
   endtask
   // main sequence
   initial
   begin
      int i;
      {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY} <= 6'h00;
      {AWADDR, ARADDR, AWPROT, ARPROT, WSTRB} <= 26'h0;
      WDATA <= 32'h0;
      repeat (4) @(posedge CORE_CLK);
      RST_N <= 1'h1;
      `CHK({tx, rx}, 10'h000)
      rd(RXGCA_ALIAS_OFS, 32'h00000000, RXGCA_RESP_OKAY);
      wr(RXGCA_GLOBAL_OFS, 32'h00001F1F, 4'hF, RXGCA_RESP_OKAY);
      rd(RXGCA_ALIAS_OFS, 32'h00001F1F, RXGCA_RESP_OKAY);
      // reserved bits set, receive bits cleared; the alias leaves the transmit bits set
      wr(RXGCA_ALIAS_OFS, 32'hFFFFE0E0, 4'hF, RXGCA_RESP_OKAY);
      `CHK({tx, rx}, 10'h3E0)
      rd(RXGCA_ALIAS_OFS, 32'h00001F00, RXGCA_RESP_OKAY);
      // walk one receive bit at a time, with junk in every other bit
      for (i = 0; i < 5; i++)
      begin
         wr(RXGCA_ALIAS_OFS, 32'hFFFFFFE0 | (32'h1 << i), 4'hF, RXGCA_RESP_OKAY);
         `CHK(rx, 5'h01 << i)
         rd(RXGCA_GLOBAL_OFS, 32'h00001F00 | (32'h1 << i), RXGCA_RESP_OKAY);
      end
      // disabled byte lanes leave the word alone
      wr(RXGCA_ALIAS_OFS, 32'h0000000F, 4'h0, RXGCA_RESP_OKAY);
      rd(RXGCA_ALIAS_OFS, 32'h00001F10, RXGCA_RESP_OKAY);
      wr(RXGCA_ALIAS_OFS, 32'h00000000, 4'hF, RXGCA_RESP_OKAY);
      rd(RXGCA_ALIAS_OFS, 32'h00001F00, RXGCA_RESP_OKAY);
      // odd patterns in both groups pin down every release output
      wr(RXGCA_GLOBAL_OFS, 32'hFFFF0A15, 4'hF, RXGCA_RESP_OKAY);
      `CHK({tx, rx}, 10'h155)
      wr(RXGCA_GLOBAL_OFS, 32'h00001500, 4'h2, RXGCA_RESP_OKAY);
      rd(RXGCA_ALIAS_OFS, 32'h00001515, RXGCA_RESP_OKAY);
      wr(RXGCA_GLOBAL_OFS, 32'h00000000, 4'hF, RXGCA_RESP_OKAY);
      rd(RXGCA_ALIAS_OFS, 32'h00000000, RXGCA_RESP_OKAY);
      // unmapped place: error answer, store untouched
      wr(8'h44, 32'h0000001F, 4'hF, RXGCA_RESP_SLVERR);
      rd(8'h44, 32'h00000000, RXGCA_RESP_SLVERR);
      rd(RXGCA_ALIAS_OFS, 32'h00000000, RXGCA_RESP_OKAY);
      // second reset in mid-run clears everything again
      wr(RXGCA_GLOBAL_OFS, 32'h00001F1F, 4'hF, RXGCA_RESP_OKAY);
      RST_N <= 1'h0;
      repeat (2) @(posedge CORE_CLK);
      `CHK({tx, rx}, 10'h000)
      RST_N <= 1'h1;
      rd(RXGCA_GLOBAL_OFS, 32'h00000000, RXGCA_RESP_OKAY);
      close_out();
   end
endmodule
